// ### common/tpc_defs.svh
// Register offsets, field positions, reset values and timing counts of the trigger block.
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_OFS_CTRL 8'h00
`define TPC_OFS_THRESH 8'h04
`define TPC_OFS_MANUAL 8'h08
`define TPC_OFS_STATUS 8'h0C
`define TPC_OFS_XYREAD 8'h10

`define TPC_CTRL_LIVE 0
`define TPC_CTRL_HOLD 1
`define TPC_CTRL_CHA_EN 2
`define TPC_CTRL_CHB_EN 3
`define TPC_CTRL_SRC_LO 4
`define TPC_CTRL_CPL_LO 6
`define TPC_CTRL_MODE_LO 8
`define TPC_CTRL_XY 10
`define TPC_CTRL_RESET 32'h0000_000C
`define TPC_THRESH_RESET 32'h0000_0000

`define TPC_SRC_EXT 2'h0
`define TPC_SRC_CHA 2'h1
`define TPC_SRC_CHB 2'h2

`define TPC_CPL_CAP_RISE 2'h0
`define TPC_CPL_CAP_FALL 2'h1
`define TPC_CPL_DIR_RISE 2'h2
`define TPC_CPL_DIR_FALL 2'h3

`define TPC_MODE_NORM 2'h0
`define TPC_MODE_AUTO 2'h1
`define TPC_MODE_MID 2'h2

`define TPC_STAT_ARMED 0
`define TPC_STAT_SWEEP 1
`define TPC_STAT_FROZEN 2
`define TPC_STAT_WAIT 3
`define TPC_STAT_RO_DONE 4
`define TPC_STAT_WRAP_LO 16

`define TPC_EXT_HYST_MV 500
`define TPC_INT_HYST_DIV 10
`define TPC_TRIG_LAT_NS 250
`define TPC_CLK_MHZ 100
`define TPC_TRIG_LAT_CYC ((`TPC_TRIG_LAT_NS * `TPC_CLK_MHZ) / 1000)

`endif

// ### common/tpc_pkg.sv
// Types shared by the trigger and capture design files.
package tpc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SWEEP, ST_FROZEN} tpc_state_e;
endpackage

// ### design/tpc_dline_mem.sv
// Delay-line sample memory with one write port and a registered read port.
`timescale 1ns/10ps
module tpc_dline_mem #(
    parameter int AW = 10,
    parameter int DW = 20
) (
    input wire logic hclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge hclk)
    begin
        if (we)
            mem[waddr] <= wdata;
        if (re)
            rdata <= mem[raddr];
    end
endmodule

// ### design/tpc_trig_capture.sv
// Trigger detection, sweep control and mid-signal capture with an AHB-Lite register slave.
//
// How it works
// - A channel switched off writes no samples but still serves as trigger source.
// - A threshold crossing starts a sweep only while live.
// - Rising edge triggers for the two rising couplings, falling edge otherwise.
// - After a trigger, re-arm only after recrossing past threshold by the hysteresis.
// - Hysteresis is 0.5 V external, one tenth of full scale internal.
// - Normal mode sweep starts within 250 ns of the trigger.
// - Auto mode starts sweeps back to back with no trigger.
// - Trigger source is external input, channel A or channel B.
// - A switched-off source channel keeps triggering; the other channel records.
// - A manual pushbutton starts a sweep without a trigger signal.
// - Mid mode while live digitizes continuously into a quarter-memory delay line.
// - Pre-trigger samples go to sequential delay-line addresses.
// - After trigger, delay line is reordered oldest first, newest at 1024th address.
// - Reordering runs alongside post-trigger writes to the other sections.
// - A mid sweep ends with 1024 pre and 3072 post points.
// - Hold at sweep end freezes the 4096-point record against overwriting.
// - Still live after a mid sweep, delay-line writing resumes at once.
// - In XY display, A is horizontal and B vertical.
// - XY readout shows A on the left and B on the right.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`include "tpc_defs.svh"
module tpc_trig_capture #(
    parameter int SW = 10,
    parameter int MEM_AW = 12,
    parameter int DL_AW = 10,
    parameter int EXT_LSB_MV = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sample_tick,
    input wire logic [SW-1:0] chan_a_sample,
    input wire logic [SW-1:0] chan_b_sample,
    input wire logic [SW-1:0] ext_trig_sample,
    input wire logic manual_btn,
    output logic mem_we_a,
    output logic mem_we_b,
    output logic [MEM_AW-1:0] mem_addr,
    output logic [SW-1:0] mem_wdata_a,
    output logic [SW-1:0] mem_wdata_b,
    output logic sweep_active,
    output logic [SW-1:0] disp_x,
    output logic [SW-1:0] disp_y
);
    localparam int HYST_INT = (2 ** (SW - 1)) / `TPC_INT_HYST_DIV;
    localparam int HYST_EXT = `TPC_EXT_HYST_MV / EXT_LSB_MV;
    localparam int LAT_CYC = `TPC_TRIG_LAT_CYC;
    localparam logic [MEM_AW-1:0] PRE_PTS = MEM_AW'(2 ** DL_AW);
    localparam logic [MEM_AW-1:0] LAST_ADDR = '1;
    localparam logic [DL_AW-1:0] DL_LAST = '1;

    tpc_pkg::tpc_state_e state_reg, state_next;
    logic [31:0] ctrl_reg, thresh_reg, hrdata_next;
    logic ahb_wr_reg, ahb_wr_next;
    logic [7:0] ahb_addr_reg;
    logic armed_reg, manual_q_reg, manual_reg_evt_reg;
    logic [SW-1:0] prev_sig_reg, disp_x_next, disp_y_next;
    logic [DL_AW-1:0] dl_ptr_reg, wrap_pos_reg, ro_idx_reg;
    logic [MEM_AW-1:0] post_addr_reg;
    logic post_done_reg, ro_done_reg, ro_pend_reg, ro_have_reg;
    logic [2*SW-1:0] ro_data_reg, dl_rdata;

    // Register bus decode.
    wire bus_take = hsel && hready && htrans[1];
    wire bus_word = hsize == 3'b010;
    wire wr_ctrl = ahb_wr_reg && ahb_addr_reg == `TPC_OFS_CTRL;
    wire wr_thresh = ahb_wr_reg && ahb_addr_reg == `TPC_OFS_THRESH;
    wire wr_manual = ahb_wr_reg && ahb_addr_reg == `TPC_OFS_MANUAL;

    wire live = ctrl_reg[`TPC_CTRL_LIVE];
    wire hold = ctrl_reg[`TPC_CTRL_HOLD];
    wire cha_en = ctrl_reg[`TPC_CTRL_CHA_EN];
    wire chb_en = ctrl_reg[`TPC_CTRL_CHB_EN];
    wire [1:0] src = ctrl_reg[`TPC_CTRL_SRC_LO +: 2];
    wire [1:0] cpl = ctrl_reg[`TPC_CTRL_CPL_LO +: 2];
    wire [1:0] mode = ctrl_reg[`TPC_CTRL_MODE_LO +: 2];
    wire xy_en = ctrl_reg[`TPC_CTRL_XY];
    wire mode_mid = mode == `TPC_MODE_MID;
    wire mode_auto = mode == `TPC_MODE_AUTO;

    // The source mux ignores the channel enables, so a dark channel still triggers.
    wire [SW-1:0] trig_sig = (src == `TPC_SRC_CHA) ? chan_a_sample :
                             (src == `TPC_SRC_CHB) ? chan_b_sample : ext_trig_sample;
    wire rising = cpl == `TPC_CPL_CAP_RISE || cpl == `TPC_CPL_DIR_RISE;
    wire signed [SW+1:0] cur_x = {{2{trig_sig[SW-1]}}, trig_sig};
    wire signed [SW+1:0] prev_x = {{2{prev_sig_reg[SW-1]}}, prev_sig_reg};
    wire signed [SW+1:0] thr_x = {{2{thresh_reg[SW-1]}}, thresh_reg[SW-1:0]};
    wire signed [SW+1:0] hyst_x = (src == `TPC_SRC_EXT) ? (SW+2)'(HYST_EXT)
                                                         : (SW+2)'(HYST_INT);
    wire cross_up = prev_x < thr_x && cur_x >= thr_x;
    wire cross_dn = prev_x > thr_x && cur_x <= thr_x;
    wire crossing = rising ? cross_up : cross_dn;
    wire rearm = rising ? (cur_x <= thr_x - hyst_x) : (cur_x >= thr_x + hyst_x);
    wire trig_evt = sample_tick && armed_reg && crossing;
    wire manual_evt = (manual_btn && !manual_q_reg) || manual_reg_evt_reg;

    wire in_wait = state_reg == tpc_pkg::ST_WAIT;
    wire in_sweep = state_reg == tpc_pkg::ST_SWEEP;
    wire go = in_wait && live && (trig_evt || mode_auto || manual_evt);
    wire pre_wr = sample_tick && in_wait && live && mode_mid;
    wire post_wr = sample_tick && in_sweep && !post_done_reg;
    wire tick_wr = pre_wr || post_wr;
    // Sample writes own the memory port; reordering fills the idle cycles.
    wire ro_wr = ro_have_reg && !tick_wr;
    wire ro_rd = in_sweep && mode_mid && !ro_done_reg && !ro_pend_reg && !ro_have_reg;
    wire ro_last = ro_idx_reg == DL_LAST;
    wire sweep_end = in_sweep && post_done_reg && (ro_done_reg || !mode_mid);
    wire [MEM_AW-1:0] mem_addr_next = pre_wr ? MEM_AW'(dl_ptr_reg) :
                                      post_wr ? post_addr_reg : MEM_AW'(ro_idx_reg);
    wire [SW-1:0] wdat_a_next = tick_wr ? chan_a_sample : ro_data_reg[2*SW-1:SW];
    wire [SW-1:0] wdat_b_next = tick_wr ? chan_b_sample : ro_data_reg[SW-1:0];
    wire mem_wr_any = tick_wr || ro_wr;
    wire [DL_AW-1:0] ro_raddr = wrap_pos_reg + ro_idx_reg;
    wire [MEM_AW-1:0] post_start = mode_mid ? PRE_PTS : '0;

    wire [31:0] status_word = {{(16 - DL_AW){1'b0}}, wrap_pos_reg, 11'h000,
                               ro_done_reg, in_wait, state_reg == tpc_pkg::ST_FROZEN,
                               in_sweep, armed_reg};
    // Left half of the readout carries channel A, right half channel B.
    wire [31:0] xy_word = {{(16 - SW){disp_x[SW-1]}}, disp_x,
                           {(16 - SW){disp_y[SW-1]}}, disp_y};
    wire [7:0] rd_ofs = haddr[7:0];
    wire rd_hit = bus_take && !hwrite && haddr[31:8] == 24'h00_0000;

    assign ahb_wr_next = bus_take && hwrite && bus_word;

    always_comb
    begin
        hrdata_next = 32'h0000_0000;
        if (rd_hit)
        begin
            unique case (rd_ofs)
                `TPC_OFS_CTRL: hrdata_next = ctrl_reg;
                `TPC_OFS_THRESH: hrdata_next = thresh_reg;
                `TPC_OFS_STATUS: hrdata_next = status_word;
                `TPC_OFS_XYREAD: hrdata_next = xy_word;
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // XY plot coordinates: A sets horizontal, B sets vertical.
    assign disp_x_next = (sample_tick && xy_en) ? chan_a_sample : disp_x;
    assign disp_y_next = (sample_tick && xy_en) ? chan_b_sample : disp_y;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            tpc_pkg::ST_IDLE:
                if (live)
                    state_next = tpc_pkg::ST_WAIT;
            tpc_pkg::ST_WAIT:
                if (!live)
                    state_next = tpc_pkg::ST_IDLE;
                else if (go)
                    state_next = tpc_pkg::ST_SWEEP;
            tpc_pkg::ST_SWEEP:
                if (sweep_end)
                begin
                    if (hold)
                        state_next = tpc_pkg::ST_FROZEN;
                    else if (live)
                        state_next = tpc_pkg::ST_WAIT;
                    else
                        state_next = tpc_pkg::ST_IDLE;
                end
            tpc_pkg::ST_FROZEN:
                if (!hold)
                    state_next = live ? tpc_pkg::ST_WAIT : tpc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ahb_wr_reg <= 1'b0;
            ahb_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_reg <= `TPC_CTRL_RESET;
            thresh_reg <= `TPC_THRESH_RESET;
            manual_reg_evt_reg <= 1'b0;
        end
        else
        begin
            ahb_wr_reg <= ahb_wr_next;
            if (bus_take)
                ahb_addr_reg <= haddr[7:0];
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (wr_ctrl)
                ctrl_reg <= hwdata;
            if (wr_thresh)
                thresh_reg <= hwdata;
            manual_reg_evt_reg <= wr_manual && hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= tpc_pkg::ST_IDLE;
            armed_reg <= 1'b1;
            prev_sig_reg <= '0;
            manual_q_reg <= 1'b0;
            sweep_active <= 1'b0;
            disp_x <= '0;
            disp_y <= '0;
        end
        else
        begin
            state_reg <= state_next;
            manual_q_reg <= manual_btn;
            sweep_active <= state_next == tpc_pkg::ST_SWEEP;
            disp_x <= disp_x_next;
            disp_y <= disp_y_next;
            if (sample_tick)
            begin
                prev_sig_reg <= trig_sig;
                if (armed_reg && crossing)
                    armed_reg <= 1'b0;
                else if (!armed_reg && rearm)
                    armed_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dl_ptr_reg <= '0;
            wrap_pos_reg <= '0;
            post_addr_reg <= '0;
            post_done_reg <= 1'b0;
        end
        else
        begin
            if (pre_wr)
                dl_ptr_reg <= dl_ptr_reg + 1'b1;
            if (go)
            begin
                wrap_pos_reg <= pre_wr ? dl_ptr_reg + 1'b1 : dl_ptr_reg;
                post_addr_reg <= post_start;
                post_done_reg <= 1'b0;
            end
            else if (post_wr)
            begin
                post_addr_reg <= post_addr_reg + 1'b1;
                post_done_reg <= post_addr_reg == LAST_ADDR;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ro_idx_reg <= '0;
            ro_done_reg <= 1'b0;
            ro_pend_reg <= 1'b0;
            ro_have_reg <= 1'b0;
            ro_data_reg <= '0;
        end
        else
        begin
            ro_pend_reg <= ro_rd;
            if (go)
            begin
                ro_idx_reg <= '0;
                ro_done_reg <= !mode_mid;
                ro_have_reg <= 1'b0;
            end
            else if (ro_pend_reg)
            begin
                ro_data_reg <= dl_rdata;
                ro_have_reg <= 1'b1;
            end
            else if (ro_wr)
            begin
                ro_have_reg <= 1'b0;
                ro_idx_reg <= ro_idx_reg + 1'b1;
                ro_done_reg <= ro_last;
            end
        end
    end

    // Disabled channels lose only their write lane; the trigger path is untouched.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mem_we_a <= 1'b0;
            mem_we_b <= 1'b0;
            mem_addr <= '0;
            mem_wdata_a <= '0;
            mem_wdata_b <= '0;
        end
        else
        begin
            mem_we_a <= mem_wr_any && cha_en;
            mem_we_b <= mem_wr_any && chb_en;
            mem_addr <= mem_addr_next;
            mem_wdata_a <= wdat_a_next;
            mem_wdata_b <= wdat_b_next;
        end
    end

    // A private copy of the delay line lets the reorder read while the frame memory is written.
    tpc_dline_mem #(
        .AW(DL_AW),
        .DW(2 * SW)
    ) u_dline (
        .hclk(hclk),
        .we(pre_wr),
        .waddr(dl_ptr_reg),
        .wdata({chan_a_sample, chan_b_sample}),
        .re(ro_rd),
        .raddr(ro_raddr),
        .rdata(dl_rdata)
    );

    sequence seq_norm_trig;
        in_wait && live && trig_evt && mode == `TPC_MODE_NORM;
    endsequence

    sequence seq_sweep_on;
        sweep_active;
    endsequence

    AST_LANE_A_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        mem_we_a |-> $past(cha_en)) else $error("channel A written while off");
    AST_LIVE_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_wait && state_next == tpc_pkg::ST_SWEEP) |-> live)
        else $error("sweep started while not live");
    AST_EDGE_DIR: assert property (@(posedge hclk) disable iff (!hresetn)
        (trig_evt && !cpl[0]) |-> (prev_x < thr_x && cur_x >= thr_x))
        else $error("rising trigger without upward crossing");
    AST_DISARM: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_evt |=> !armed_reg) else $error("detector still armed after trigger");
    AST_START_LAT: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_norm_trig |-> ##[1:LAT_CYC] seq_sweep_on) else $error("sweep start too late");
    AST_AUTO_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_wait && live && mode_auto) |=> in_sweep) else $error("auto mode did not sweep");
    AST_MANUAL: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_wait && live && manual_evt) |=> state_reg == tpc_pkg::ST_SWEEP)
        else $error("manual start ignored");
    AST_DL_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (pre_wr && dl_ptr_reg == DL_LAST) |=> dl_ptr_reg == '0)
        else $error("delay line did not wrap");
    AST_RO_REGION: assert property (@(posedge hclk) disable iff (!hresetn)
        ro_wr |=> mem_addr < PRE_PTS) else $error("reorder wrote outside delay line");
    AST_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == tpc_pkg::ST_FROZEN) [*2] |-> !mem_we_a && !mem_we_b)
        else $error("frozen record overwritten");
endmodule

// ### sim/tpc_frame_mem_model.sv
// Behavioural frame memory that records the A and B lanes written by the block.
`timescale 1ns/10ps
module tpc_frame_mem_model (
    input wire logic hclk,
    input wire logic we_a,
    input wire logic we_b,
    input wire logic [11:0] addr,
    input wire logic [9:0] wdata_a,
    input wire logic [9:0] wdata_b
);
    logic [9:0] mem_a [4096];
    logic [9:0] mem_b [4096];
    int cnt_a = 0;
    int cnt_b = 0;

    // Both lanes share one address, so an A and B pair always lands on the same word.
    always @(posedge hclk)
    begin
        if (we_a === 1'b1)
        begin
            mem_a[addr] <= wdata_a;
            cnt_a <= cnt_a + 1;
        end
        if (we_b === 1'b1)
        begin
            mem_b[addr] <= wdata_b;
            cnt_b <= cnt_b + 1;
        end
    end
endmodule

// ### sim/trigger_pretrigger_capture_ctrl_tb.sv
// Self-checking testbench for the trigger and mid-signal capture block.
`timescale 1ns/10ps
`include "tpc_defs.svh"
module trigger_pretrigger_capture_ctrl_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic sample_tick = 1'b0;
    logic [9:0] chan_a_sample = 10'h000;
    logic [9:0] chan_b_sample = 10'h000;
    logic [9:0] ext_trig_sample = 10'h000;
    logic manual_btn = 1'b0;
    logic mem_we_a;
    logic mem_we_b;
    logic [11:0] mem_addr;
    logic [9:0] mem_wdata_a;
    logic [9:0] mem_wdata_b;
    logic sweep_active;
    logic [9:0] disp_x;
    logic [9:0] disp_y;
    logic [1:0] tcnt = 2'h0;
    logic ramp = 1'b0;
    logic [31:0] rd;
    logic [9:0] tv;
    logic [9:0] ta;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    int c0;
    int ca;
    int cb;
    int hv [8] = '{0, 100, 51, 50, 10, 0, 50, 51};
    int he [8] = '{2, 0, 0, 1, 2, 0, 0, 1};

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    tpc_trig_capture i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_tick(sample_tick),
        .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
        .ext_trig_sample(ext_trig_sample), .manual_btn(manual_btn), .mem_we_a(mem_we_a),
        .mem_we_b(mem_we_b), .mem_addr(mem_addr), .mem_wdata_a(mem_wdata_a),
        .mem_wdata_b(mem_wdata_b), .sweep_active(sweep_active), .disp_x(disp_x),
        .disp_y(disp_y));

    tpc_frame_mem_model i_mem (.hclk(hclk), .we_a(mem_we_a), .we_b(mem_we_b),
        .addr(mem_addr), .wdata_a(mem_wdata_a), .wdata_b(mem_wdata_b));

    // A tick every third cycle leaves two idle cycles per tick for the reorder writes.
    always @(posedge hclk)
    begin
        tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
        sample_tick <= (tcnt == 2'h2);
        if (ramp && tcnt == 2'h2)
        begin
            chan_a_sample <= chan_a_sample + 10'h001;
            chan_b_sample <= chan_b_sample + 10'h001;
        end
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ticks(input int k);
        repeat (k)
        begin
            do @(posedge hclk); while (sample_tick !== 1'b1);
        end
    endtask

    task automatic wait_sw(input string nm, input logic lvl, input int lim);
        c0 = 0;
        while (sweep_active !== lvl && c0 < lim)
        begin
            @(posedge hclk);
            c0 = c0 + 1;
        end
        chk32(nm, {31'h0000_0000, lvl}, {31'h0000_0000, sweep_active});
    endtask

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'(`TPC_OFS_CTRL), 32'h0000_0000);
        chk32("ctrl reset", `TPC_CTRL_RESET, rd);
        chk32("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        ahb(1'b0, 32'(`TPC_OFS_THRESH), 32'h0000_0000);
        chk32("thresh reset", `TPC_THRESH_RESET, rd);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk32("unmapped", 32'h0000_0000, rd);
        $display("test reset done");

        // Not live: crossings must disarm the detector but never start a sweep.
        ahb(1'b1, 32'(`TPC_OFS_THRESH), 32'h0000_0064);
        for (n = 0; n < 8; n++)
        begin
            if (n == 4)
            begin
                ahb(1'b1, 32'(`TPC_OFS_THRESH), 32'h0000_0000);
                ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_00DC);
            end
            if (n < 4)
                ext_trig_sample <= 10'(hv[n]);
            else
                chan_a_sample <= 10'(hv[n]);
            ticks(2);
            ahb(1'b0, 32'(`TPC_OFS_STATUS), 32'h0000_0000);
            if (he[n] != 2)
                chk32("armed", 32'(he[n]), {31'h0000_0000, rd[0]});
        end
        chk32("sweep while idle", 32'h0000_0000, {31'h0000_0000, sweep_active});
        ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_040C);
        chan_a_sample <= 10'h3FD;
        chan_b_sample <= 10'h005;
        ticks(2);
        chk32("disp x", 32'h0000_03FD, {22'h00_0000, disp_x});
        chk32("disp y", 32'h0000_0005, {22'h00_0000, disp_y});
        ahb(1'b0, 32'(`TPC_OFS_XYREAD), 32'h0000_0000);
        chk32("xy readout", 32'hFFFD_0005, rd);
        $display("test hysteresis and xy done");

        chan_a_sample <= 10'h000;
        ahb(1'b1, 32'(`TPC_OFS_THRESH), 32'h0000_0064);
        ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_0019);
        ticks(3);
        ca = i_mem.cnt_a;
        cb = i_mem.cnt_b;
        chan_a_sample <= 10'h096;
        ticks(1);
        wait_sw("trigger start", 1'b1, 25);
        wait_sw("normal end", 1'b0, 13000);
        chk32("lane a writes", 32'(ca), 32'(i_mem.cnt_a));
        chk32("lane b writes", 32'(cb + 4096), 32'(i_mem.cnt_b));
        manual_btn <= 1'b1;
        @(posedge hclk);
        wait_sw("button start", 1'b1, 25);
        manual_btn <= 1'b0;
        wait_sw("button end", 1'b0, 13000);
        $display("test normal done");

        ext_trig_sample <= 10'h000;
        ramp <= 1'b1;
        ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_020F);
        ticks(1100);
        ext_trig_sample <= 10'h0C8;
        ticks(1);
        tv = chan_b_sample;
        ta = chan_a_sample;
        wait_sw("mid start", 1'b1, 25);
        rd = 32'h0000_0000;
        for (n = 0; n < 6000 && rd[2] !== 1'b1; n++)
            ahb(1'b0, 32'(`TPC_OFS_STATUS), 32'h0000_0000);
        chk32("frozen", 32'h0000_0014, {27'h000_0000, rd[4:0]});
        chk32("wrap", 32'h0000_004D, {22'h00_0000, rd[25:16]});
        for (n = 0; n < 4096; n++)
        begin
            chk32("record", 32'(10'(tv + n - 1023)), 32'(i_mem.mem_b[n]));
            chk32("record a", 32'(10'(ta + n - 1023)), 32'(i_mem.mem_a[n]));
        end
        cb = i_mem.cnt_b;
        repeat (300) @(posedge hclk);
        chk32("frozen writes", 32'(cb), 32'(i_mem.cnt_b));
        ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_020D);
        c0 = 0;
        while (mem_we_b !== 1'b1 && c0 < 30)
        begin
            @(posedge hclk);
            c0 = c0 + 1;
        end
        chk32("resume", 32'h0000_0001, 32'(mem_we_b === 1'b1 && mem_addr < 12'h400));
        $display("test mid done");

        ahb(1'b1, 32'(`TPC_OFS_CTRL), 32'h0000_010D);
        wait_sw("auto start", 1'b1, 30);
        wait_sw("auto end", 1'b0, 13000);
        wait_sw("auto again", 1'b1, 30);
        $display("test auto done");
        print_verdict();
    end
endmodule
